// File: include/tlff_pkg.sv
`default_nettype none
package tlff_pkg;
  // server frame tail
  localparam int          TLFF_PATH_W       = 10;
  localparam int          TLFF_PATH_SOM_BIT = 9;
  localparam int          TLFF_PATH_DV_BIT  = 8;
  localparam int          TLFF_RSVD_W       = 68;
  localparam int          TLFF_CRC_W        = 16;
  localparam int          TLFF_MSG_MAX      = 64;
  localparam int          TLFF_SLOT_MOD     = 100;
  // path traceability item types
  localparam logic [7:0]  TLFF_T_ROOT_V4    = 8'h01;
  localparam logic [7:0]  TLFF_T_ROOT_PORT  = 8'h02;
  localparam logic [7:0]  TLFF_T_SRV_V4     = 8'h03;
  localparam logic [7:0]  TLFF_T_SRV_PORT   = 8'h04;
  localparam logic [7:0]  TLFF_T_ROOT_V6    = 8'h05;
  localparam logic [7:0]  TLFF_T_SRV_V6     = 8'h06;
  localparam logic [7:0]  TLFF_T_ROOT_VER   = 8'h07;
  localparam logic [7:0]  TLFF_T_SRV_VER    = 8'h08;
  localparam logic [7:0]  TLFF_T_PT_EOT     = 8'h09;
  // path location item types
  localparam logic [7:0]  TLFF_T_UTC        = 8'h0b;
  localparam logic [7:0]  TLFF_T_QUAL       = 8'h0d;
  localparam logic [7:0]  TLFF_T_DOP        = 8'h0f;
  localparam logic [7:0]  TLFF_T_ALT        = 8'h10;
  localparam logic [7:0]  TLFF_T_LOC_EOT    = 8'h11;
  localparam logic [7:0]  TLFF_LEN_V4       = 8'h04;
  localparam logic [7:0]  TLFF_LEN_V6       = 8'h10;
  localparam logic [7:0]  TLFF_LEN_ONE      = 8'h01;
  localparam logic [7:0]  TLFF_LEN_UTC      = 8'h06;
  localparam logic [7:0]  TLFF_LEN_DOP      = 8'h05;
  localparam logic [7:0]  TLFF_LEN_ALT      = 8'h09;
  localparam logic [7:0]  TLFF_EOT_VAL      = 8'h00;
  localparam logic [7:0]  TLFF_ASCII_0      = 8'h30;
  localparam logic [7:0]  TLFF_ASCII_1      = 8'h31;
  localparam logic [7:0]  TLFF_ASCII_DOT    = 8'h2e;
  // location rate limit
  localparam int          TLFF_LOC_GAP_S    = 5;
  localparam int          TLFF_CLK_HZ       = 25000000;
  localparam longint      TLFF_LOC_GAP_CYC  = longint'(TLFF_LOC_GAP_S) * TLFF_CLK_HZ;
  // client frame
  localparam int          TLFF_PRE_W        = 68;
  localparam logic [67:0] TLFF_PREAMBLE     = 68'haaaaaaaaaaaaaaaa6;
  localparam int          TLFF_CFR_W        = 234;
  localparam int          TLFF_CPAY_W       = 150;
  localparam logic [21:0] TLFF_RSVD22       = 22'h3fffff;
  localparam logic [9:0]  TLFF_RSVD10       = 10'h3ff;
  localparam logic [67:0] TLFF_RSVD68       = 68'hfffffffffffffffff;
  localparam logic [15:0] TLFF_CRC_INIT     = 16'hffff;
  typedef enum logic [3:0] {
    TLFF_IT_ROOT_ADDR = 4'h0,
    TLFF_IT_ROOT_PORT = 4'h1,
    TLFF_IT_SRV_ADDR  = 4'h2,
    TLFF_IT_SRV_PORT  = 4'h3,
    TLFF_IT_ROOT_VER  = 4'h4,
    TLFF_IT_SRV_VER   = 4'h5,
    TLFF_IT_PT_EOT    = 4'h6,
    TLFF_IT_UTC       = 4'h7,
    TLFF_IT_QUAL      = 4'h8,
    TLFF_IT_DOP       = 4'h9,
    TLFF_IT_ALT       = 4'ha,
    TLFF_IT_LOC_EOT   = 4'hb,
    TLFF_IT_DONE      = 4'hc
  } tlff_item_t;
  typedef enum logic [1:0] {
    TLFF_PH_TYPE = 2'h0,
    TLFF_PH_LEN  = 2'h1,
    TLFF_PH_VAL  = 2'h2
  } tlff_phase_t;
endpackage : tlff_pkg
`default_nettype wire

// File: include/tlff_crc_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries crc control between the framer and its crc engine
interface tlff_crc_if;
  logic        clr;
  logic        en;
  logic        bit_in;
  logic [15:0] crc;
  modport owner (output clr, output en, output bit_in, input crc);
  modport engine (input clr, input en, input bit_in, output crc);
endinterface : tlff_crc_if
`default_nettype wire

// File: src/tlff_crc16.sv
`timescale 1ns/1ps
`default_nettype none
// serial crc-16; polynomial is a parameter since the annex sets it
module tlff_crc16
  import tlff_pkg::*;
#(
  parameter logic [15:0] POLY = 16'h1021
)(
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  tlff_crc_if.engine crc_if
);
  logic [15:0] crc_q;
  logic        fb;

  assign fb         = crc_q[15] ^ crc_if.bit_in;
  assign crc_if.crc = crc_q;

  // one bit per enable, msb first
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || crc_if.clr)
      crc_q <= TLFF_CRC_INIT;
    else if (crc_if.en)
      crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
  end
endmodule : tlff_crc16
`default_nettype wire

// File: src/tlff_framer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - path data byte sits in bits 7:0 of the 10-bit path field.
// - root ipv4 address is type 1 len 4; root port type 2 len 1.
// - non-root server adds own ipv4 type 3 and port type 4.
// - ipv6 addresses use type 5 root, type 6 non-root, 16 bytes.
// - versions sent as type 7 root and type 8 non-root, one byte.
// - traceability message ends with type 9, length 1, value 0x00.
// - subtending server forwards root address unchanged plus its own.
// - root server omits non-root address items.
// - each item is type byte, length byte, then value bytes.
// - location message optional, at most once every 5 seconds.
// - subtending server relays root location to all client ports; this block sends it on o_path_field only.
// - utc fix time is type 11 with six ascii digits hhmmss.
// - fix quality type 13, ascii 0 invalid, ascii 1 valid.
// - dilution item type 15, five chars, 00.00 when position suspended.
// - altitude type 16, nine chars: sign, 00000.0..04000.0, M.
// - location message ends with type 17, length 1, value 0x00.
// - server frame has 68 reserved one bits before the crc.
// - client frame opens with 68-bit preamble ending 0110.
// - client fields follow in fixed order with reserved ones.
// - client crc covers all bits except the preamble.
// - phase is 16-bit two's complement in upper bits of 24.
// - device type byte names client kind and timing source.
// - bit 9 marks message start for one frame; bit 8 data valid.
// - message slots are 10 ms, start at timestamp mod 100, max 64 bytes.
module tlff_framer
  import tlff_pkg::*;
#(
  parameter longint LOC_GAP_CYC = TLFF_LOC_GAP_CYC
)(
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  // server tail: one path field per frame
  input  wire logic         i_frame_tick,
  input  wire logic [31:0]  i_upper_ts,
  input  wire logic         i_pps_flag,
  input  wire logic         i_is_root,
  input  wire logic         i_use_ipv6,
  input  wire logic [127:0] i_root_addr,
  input  wire logic [7:0]   i_root_port,
  input  wire logic [7:0]   i_root_ver,
  input  wire logic [127:0] i_own_addr,
  input  wire logic [7:0]   i_own_port,
  input  wire logic [7:0]   i_own_ver,
  input  wire logic         i_loc_en,
  input  wire logic [47:0]  i_utc_ascii,
  input  wire logic         i_fix_valid,
  input  wire logic         i_pos_suspended,
  input  wire logic [39:0]  i_dop_ascii,
  input  wire logic [71:0]  i_alt_ascii,
  output logic [9:0]        o_path_field,
  output logic [67:0]       o_srv_rsvd,
  output logic              o_loc_sent,
  // client frame serialiser, one bit per link clock rise
  input  wire logic         i_link_clk,
  input  wire logic         i_cl_start,
  input  wire logic [7:0]   i_dev_type,
  input  wire logic [7:0]   i_status_flags,
  input  wire logic [15:0]  i_phase,
  input  wire logic [9:0]   i_version,
  output logic              o_cl_bit,
  output logic              o_cl_bit_vld,
  output logic              o_cl_busy
);
  // ---------------- server path message ----------------
  tlff_item_t  item_q;
  tlff_phase_t ph_q;
  logic [4:0]  vidx_q;
  logic        loc_q;
  logic        som_pend_q;
  logic [6:0]  cnt_q;
  logic        pt_due_q;
  logic [63:0] gap_q;
  logic        in_slot;
  logic [7:0]  ty;
  logic [7:0]  ln;
  logic [7:0]  vb;
  logic [127:0] addr;

  assign in_slot = (i_upper_ts % TLFF_SLOT_MOD) == 32'h0;
  assign o_srv_rsvd = TLFF_RSVD68;

  // type/length/value lookup per item
  always_comb
  begin
    ty = TLFF_EOT_VAL;
    ln = TLFF_LEN_ONE;
    vb = TLFF_EOT_VAL;
    addr = 128'h0;
    case (item_q)
      TLFF_IT_ROOT_ADDR:
      begin
        ty = i_use_ipv6 ? TLFF_T_ROOT_V6 : TLFF_T_ROOT_V4;
        ln = i_use_ipv6 ? TLFF_LEN_V6 : TLFF_LEN_V4;
        addr = i_use_ipv6 ? i_root_addr : {i_root_addr[31:0], 96'h0};
        vb = addr[127 - 8*vidx_q -: 8];
      end
      TLFF_IT_ROOT_PORT: begin ty = TLFF_T_ROOT_PORT; vb = i_root_port; end
      TLFF_IT_SRV_ADDR:
      begin
        ty = i_use_ipv6 ? TLFF_T_SRV_V6 : TLFF_T_SRV_V4;
        ln = i_use_ipv6 ? TLFF_LEN_V6 : TLFF_LEN_V4;
        addr = i_use_ipv6 ? i_own_addr : {i_own_addr[31:0], 96'h0};
        vb = addr[127 - 8*vidx_q -: 8];
      end
      TLFF_IT_SRV_PORT: begin ty = TLFF_T_SRV_PORT; vb = i_own_port; end
      TLFF_IT_ROOT_VER: begin ty = TLFF_T_ROOT_VER; vb = i_root_ver; end
      TLFF_IT_SRV_VER:  begin ty = TLFF_T_SRV_VER; vb = i_own_ver; end
      TLFF_IT_PT_EOT:   ty = TLFF_T_PT_EOT;
      TLFF_IT_UTC:
      begin
        ty = TLFF_T_UTC;
        ln = TLFF_LEN_UTC;
        vb = i_utc_ascii[47 - 8*vidx_q -: 8];
      end
      TLFF_IT_QUAL:
      begin
        ty = TLFF_T_QUAL;
        vb = i_fix_valid ? TLFF_ASCII_1 : TLFF_ASCII_0;
      end
      TLFF_IT_DOP:
      begin
        ty = TLFF_T_DOP;
        ln = TLFF_LEN_DOP;
        if (i_pos_suspended)
          vb = (vidx_q == 5'd2) ? TLFF_ASCII_DOT : TLFF_ASCII_0;
        else
          vb = i_dop_ascii[39 - 8*vidx_q -: 8];
      end
      TLFF_IT_ALT:
      begin
        ty = TLFF_T_ALT;
        ln = TLFF_LEN_ALT;
        vb = i_alt_ascii[71 - 8*vidx_q -: 8];
      end
      TLFF_IT_LOC_EOT:  ty = TLFF_T_LOC_EOT;
      default:          ty = TLFF_EOT_VAL;
    endcase
  end

  // next item after the current one, root skips own items
  function automatic tlff_item_t tlff_next(input tlff_item_t it, input logic root);
    tlff_item_t n;
    n = TLFF_IT_DONE;
    case (it)
      TLFF_IT_ROOT_ADDR: n = TLFF_IT_ROOT_PORT;
      TLFF_IT_ROOT_PORT: n = root ? TLFF_IT_ROOT_VER : TLFF_IT_SRV_ADDR;
      TLFF_IT_SRV_ADDR:  n = TLFF_IT_SRV_PORT;
      TLFF_IT_SRV_PORT:  n = TLFF_IT_ROOT_VER;
      TLFF_IT_ROOT_VER:  n = root ? TLFF_IT_PT_EOT : TLFF_IT_SRV_VER;
      TLFF_IT_SRV_VER:   n = TLFF_IT_PT_EOT;
      TLFF_IT_UTC:       n = TLFF_IT_QUAL;
      TLFF_IT_QUAL:      n = TLFF_IT_DOP;
      TLFF_IT_DOP:       n = TLFF_IT_ALT;
      TLFF_IT_ALT:       n = TLFF_IT_LOC_EOT;
      default:           n = TLFF_IT_DONE;
    endcase
    return n;
  endfunction : tlff_next

  // pps arms traceability; next slot carries it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      pt_due_q <= 1'b0;
    else if (i_pps_flag)
      pt_due_q <= 1'b1; // set wins over the clear below
    else if (i_frame_tick && in_slot && item_q == TLFF_IT_DONE)
      pt_due_q <= 1'b0;
  end

  // location spacing counter
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      gap_q <= 64'h0;
    else if (i_frame_tick && in_slot && item_q == TLFF_IT_DONE && !pt_due_q && i_loc_en && gap_q == 64'h0)
      gap_q <= 64'(LOC_GAP_CYC);
    else if (gap_q != 64'h0)
      gap_q <= gap_q - 64'h1;
  end

  // message sequencer, one byte per frame
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      item_q       <= TLFF_IT_DONE;
      ph_q         <= TLFF_PH_TYPE;
      vidx_q       <= 5'h0;
      loc_q        <= 1'b0;
      som_pend_q   <= 1'b0;
      cnt_q        <= 7'h0;
      o_path_field <= 10'h000;
      o_loc_sent   <= 1'b0;
    end
    else if (!i_frame_tick)
      o_loc_sent <= 1'b0; // done flag is a one-cycle pulse, not held to the next tick
    else
    begin
      o_loc_sent <= 1'b0;
      if (item_q == TLFF_IT_DONE)
      begin
        o_path_field <= 10'h000;
        if (in_slot && pt_due_q)
        begin
          item_q <= TLFF_IT_ROOT_ADDR;
          loc_q  <= 1'b0;
          som_pend_q <= 1'b1;
          cnt_q  <= 7'h0;
        end
        else if (in_slot && i_loc_en && gap_q == 64'h0)
        begin
          item_q <= TLFF_IT_UTC;
          loc_q  <= 1'b1;
          som_pend_q <= 1'b1;
          cnt_q  <= 7'h0;
        end
        ph_q   <= TLFF_PH_TYPE;
        vidx_q <= 5'h0;
      end
      else if (cnt_q < 7'(TLFF_MSG_MAX))
      begin
        // som high only on first byte frame
        o_path_field[TLFF_PATH_SOM_BIT] <= som_pend_q;
        o_path_field[TLFF_PATH_DV_BIT]  <= 1'b1;
        som_pend_q <= 1'b0;
        cnt_q      <= cnt_q + 7'h1;
        case (ph_q)
          TLFF_PH_TYPE:
          begin
            o_path_field[7:0] <= ty;
            ph_q <= TLFF_PH_LEN;
          end
          TLFF_PH_LEN:
          begin
            o_path_field[7:0] <= ln;
            ph_q <= TLFF_PH_VAL;
          end
          TLFF_PH_VAL:
          begin
            o_path_field[7:0] <= vb;
            if (vidx_q == 5'(ln - 8'h1))
            begin
              vidx_q <= 5'h0;
              ph_q   <= TLFF_PH_TYPE;
              item_q <= tlff_next(item_q, i_is_root);
              if (tlff_next(item_q, i_is_root) == TLFF_IT_DONE)
                o_loc_sent <= loc_q;
            end
            else
              vidx_q <= vidx_q + 5'h1;
          end
          default: ph_q <= TLFF_PH_TYPE;
        endcase
      end
      else
      begin
        item_q       <= TLFF_IT_DONE; // overlong message cut off
        o_path_field <= 10'h000;
      end
    end
  end

  // ---------------- client frame serialiser ----------------
  tlff_crc_if crc_if ();
  logic [1:0]  lclk_sync_q;
  logic        lclk_prev_q;
  logic        lrise;
  logic [7:0]  bidx_q;
  logic [TLFF_CPAY_W-1:0] pay_q;
  logic [67:0] pre_q;

  tlff_crc16 u_crc (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .crc_if    (crc_if.engine)
  );

  // link clock comes from outside: sync then edge
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      lclk_sync_q <= 2'b00;
      lclk_prev_q <= 1'b0;
    end
    else
    begin
      lclk_sync_q <= {lclk_sync_q[0], i_link_clk};
      lclk_prev_q <= lclk_sync_q[1];
    end
  end
  assign lrise = lclk_sync_q[1] & ~lclk_prev_q;

  // bit counter and shifters; fields latched at frame start
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      bidx_q       <= 8'h0;
      o_cl_busy    <= 1'b0;
      o_cl_bit     <= 1'b0;
      o_cl_bit_vld <= 1'b0;
      pay_q        <= '0;
      pre_q        <= '0;
    end
    else
    begin
      o_cl_bit_vld <= 1'b0;
      if (!o_cl_busy && i_cl_start)
      begin
        o_cl_busy <= 1'b1;
        bidx_q    <= 8'h0;
        pre_q     <= TLFF_PREAMBLE;
        pay_q     <= {i_dev_type, i_status_flags, TLFF_RSVD22, TLFF_RSVD10,
                      i_phase, 8'h00, i_version, TLFF_RSVD68};
      end
      else if (o_cl_busy && lrise)
      begin
        o_cl_bit_vld <= 1'b1;
        bidx_q <= bidx_q + 8'h1;
        if (bidx_q < 8'(TLFF_PRE_W))
        begin
          o_cl_bit <= pre_q[67];
          pre_q    <= {pre_q[66:0], 1'b0};
        end
        else if (bidx_q < 8'(TLFF_PRE_W + TLFF_CPAY_W))
        begin
          o_cl_bit <= pay_q[TLFF_CPAY_W-1];
          pay_q    <= {pay_q[TLFF_CPAY_W-2:0], 1'b0};
        end
        else
          o_cl_bit <= crc_if.crc[15 - 4'(bidx_q - 8'(TLFF_PRE_W + TLFF_CPAY_W))];
        // frame total already counts the preamble
        if (bidx_q == 8'(TLFF_CFR_W - 1))
          o_cl_busy <= 1'b0;
      end
    end
  end

  // crc runs over payload bits only, never the preamble
  assign crc_if.clr    = !o_cl_busy && i_cl_start;
  assign crc_if.bit_in = pay_q[TLFF_CPAY_W-1];
  assign crc_if.en     = o_cl_busy && lrise && bidx_q >= 8'(TLFF_PRE_W)
                         && bidx_q < 8'(TLFF_PRE_W + TLFF_CPAY_W);
endmodule : tlff_framer
`default_nettype wire

// File: dv/tlff_framer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tlff_framer_monitor
  import tlff_pkg::*;
#(
  parameter longint LOC_GAP_CYC = TLFF_LOC_GAP_CYC
)(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_frame_tick,
  input  wire logic        i_cl_start,
  input  wire logic [9:0]  o_path_field,
  input  wire logic [67:0] o_srv_rsvd,
  input  wire logic        o_loc_sent,
  input  wire logic        o_cl_bit,
  input  wire logic        o_cl_bit_vld,
  input  wire logic        o_cl_busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  longint gap_q;
  // cycles since the last location message; saturates so it never wraps
  always_ff @(posedge i_clk_sys)
    if (i_reset)
      gap_q <= LOC_GAP_CYC;
    else if (o_loc_sent)
      gap_q <= 0;
    else if (gap_q < LOC_GAP_CYC)
      gap_q <= gap_q + 1;
  sequence s_take;
    i_cl_start && !o_cl_busy;
  endsequence
  sequence s_som_tick;
    o_path_field[9] && i_frame_tick;
  endsequence
  a_rsvd_ones: assert property (o_srv_rsvd == {68{1'b1}})
    else $error("server reserved bits not all ones");
  a_busy_take: assert property (s_take |=> o_cl_busy)
    else $error("frame start not taken");
  a_vld_pulse: assert property (o_cl_bit_vld |=> !o_cl_bit_vld)
    else $error("bit valid longer than one cycle");
  a_bit_hold: assert property ($changed(o_cl_bit) |-> o_cl_bit_vld)
    else $error("serial bit changed without valid");
  a_field_hold: assert property (!i_frame_tick |=> $stable(o_path_field))
    else $error("path field moved without a tick");
  a_som_single: assert property (s_som_tick |=> !o_path_field[9])
    else $error("start flag held over two frames");
  a_som_valid: assert property (o_path_field[9] |-> o_path_field[8])
    else $error("start flag without data valid");
  a_loc_tick: assert property (o_loc_sent |-> $past(i_frame_tick))
    else $error("location done not on a tick");
  a_loc_eot: assert property (o_loc_sent |-> o_path_field == 10'h100)
    else $error("location done without end byte");
  a_loc_gap: assert property (o_loc_sent |-> gap_q >= LOC_GAP_CYC - 1)
    else $error("location messages too close");
  a_loc_pulse: assert property (o_loc_sent |=> !o_loc_sent)
    else $error("location done held over two cycles");
endmodule : tlff_framer_monitor
bind tlff_framer tlff_framer_monitor #(.LOC_GAP_CYC(LOC_GAP_CYC)) u_mon (.i_clk_sys, .i_reset, .i_frame_tick,
  .i_cl_start, .o_path_field, .o_srv_rsvd, .o_loc_sent, .o_cl_bit, .o_cl_bit_vld, .o_cl_busy);
`default_nettype wire

// File: dv/tlff_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tlff_link_partner (
  input  wire logic i_clk_sys,
  input  wire logic i_run,
  input  wire logic i_bit,
  input  wire logic i_bit_vld,
  output logic      o_link_clk
);
  logic bits[$];
  // link clock stands still between frames; odd offset keeps phase apart
  initial
  begin
    o_link_clk = 1'b0;
    #37;
    forever
    begin
      #160;
      if (i_run)
        o_link_clk = ~o_link_clk;
    end
  end
  // every received bit kept for the bench to find preamble and crc
  always @(posedge i_clk_sys)
    if (i_bit_vld)
      bits.push_back(i_bit);
endmodule : tlff_link_partner
`default_nettype wire

// File: dv/timing_link_frame_fields_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timing_link_frame_fields_tb_top;
  import tlff_pkg::*;
  logic         i_clk_sys, i_reset, i_frame_tick, i_pps_flag, i_is_root, i_use_ipv6;
  logic         i_loc_en, i_fix_valid, i_pos_suspended, i_link_clk, i_cl_start;
  logic         o_loc_sent, o_cl_bit, o_cl_bit_vld, o_cl_busy;
  logic [31:0]  i_upper_ts;
  logic [127:0] i_root_addr, i_own_addr;
  logic [7:0]   i_root_port, i_root_ver, i_own_port, i_own_ver, i_dev_type, i_status_flags;
  logic [47:0]  i_utc_ascii;
  logic [39:0]  i_dop_ascii;
  logic [71:0]  i_alt_ascii;
  logic [15:0]  i_phase, crc;
  logic [9:0]   i_version, o_path_field;
  logic [67:0]  o_srv_rsvd;
  logic [149:0] pay;
  logic [233:0] frame;
  logic [7:0]   exp_q[$];
  int           num_errors, checks_done, w, loc_seen;
  integer       seed;
  tlff_framer #(
    .LOC_GAP_CYC(2000)
  ) u_tlff_framer (
    .i_clk_sys, .i_reset, .i_frame_tick, .i_upper_ts, .i_pps_flag, .i_is_root, .i_use_ipv6,
    .i_root_addr, .i_root_port, .i_root_ver, .i_own_addr, .i_own_port, .i_own_ver, .i_loc_en,
    .i_utc_ascii, .i_fix_valid, .i_pos_suspended, .i_dop_ascii, .i_alt_ascii, .o_path_field,
    .o_srv_rsvd, .o_loc_sent, .i_link_clk, .i_cl_start, .i_dev_type, .i_status_flags,
    .i_phase, .i_version, .o_cl_bit, .o_cl_bit_vld, .o_cl_busy
  );
  tlff_link_partner u_tlff_link_partner (
    .i_clk_sys, .i_run(o_cl_busy), .i_bit(o_cl_bit), .i_bit_vld(o_cl_bit_vld), .o_link_clk(i_link_clk)
  );
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // location done lasts one cycle, so count it as it passes
  always @(posedge i_clk_sys)
    if (o_loc_sent === 1'b1)
      loc_seen <= loc_seen + 1;
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // a wait that ran out ends the run at once
  task automatic guard(input int n);
    if (n >= 5000)
    begin
      num_errors++;
      $display("ERROR at %0t: wait ran out seen %0h expected %0h", $time, n, 0);
      finish_test();
    end
  endtask : guard
  // one item: type, length, value bytes msb first
  task automatic put(input logic [7:0] t, input logic [7:0] l, input logic [127:0] v);
    exp_q.push_back(t);
    exp_q.push_back(l);
    for (int k = l - 1; k >= 0; k--)
      exp_q.push_back(v[8*k +: 8]);
  endtask : put
  task automatic tick(input logic [31:0] ts);
    @(posedge i_clk_sys);
    i_frame_tick <= 1'b1;
    i_upper_ts   <= ts;
    @(posedge i_clk_sys);
    i_frame_tick <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask : tick
  // empty queue means nothing may be sent from this slot
  task automatic run_msg(input logic [31:0] ts);
    tick(ts);
    for (int n = 0; n < exp_q.size(); n++)
    begin
      tick(ts + 1 + n);
      chk(o_path_field, {n == 0, 1'b1, exp_q[n]});
    end
    tick(ts + 99);
    chk(o_path_field, 10'h000);
    exp_q.delete();
  endtask : run_msg
  initial
  begin
    seed = 32'h43f401eb;
    {i_frame_tick, i_pps_flag, i_is_root, i_use_ipv6, i_loc_en, i_fix_valid, i_pos_suspended} = '0;
    {i_cl_start, i_upper_ts, i_root_addr, i_own_addr, i_root_port, i_root_ver} = '0;
    {i_own_port, i_own_ver, i_dev_type, i_status_flags, i_phase, i_version} = '0;
    i_utc_ascii = 48'h313233343536;
    i_dop_ascii = 40'h30322e3334;
    i_alt_ascii = 72'h2b30303132332e344d;
    i_reset     = 1'b1;
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    chk(o_srv_rsvd, {68{1'b1}});
    run_msg(150); // nothing pending yet, so a tick outside a slot sends nothing
    // non-root v4, non-root v6, root v6
    for (int r = 0; r < 3; r++)
    begin
      i_is_root   <= (r == 2);
      i_use_ipv6  <= (r != 0);
      i_root_addr <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      i_own_addr  <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      {i_root_port, i_own_port, i_root_ver, i_own_ver} <= $random(seed);
      i_pps_flag  <= 1'b1;
      @(posedge i_clk_sys);
      i_pps_flag  <= 1'b0;
      put(r ? 8'h05 : 8'h01, r ? 8'h10 : 8'h04, i_root_addr);
      put(8'h02, 8'h01, i_root_port);
      if (r != 2)
        put(r ? 8'h06 : 8'h03, r ? 8'h10 : 8'h04, i_own_addr);
      if (r != 2)
        put(8'h04, 8'h01, i_own_port);
      put(8'h07, 8'h01, i_root_ver);
      if (r != 2)
        put(8'h08, 8'h01, i_own_ver);
      put(8'h09, 8'h01, 128'h0);
      run_msg(200 + 100 * r);
    end
    chk(loc_seen, 0);
    $display("path trace test done");
    i_loc_en <= 1'b1;
    // random fix quality then suspended position; a second slot soon after must stay silent
    for (int l = 0; l < 2; l++)
    begin
      i_pos_suspended <= l[0];
      i_fix_valid     <= $random(seed);
      repeat (2100) @(posedge i_clk_sys);
      put(8'h0b, 8'h06, i_utc_ascii);
      put(8'h0d, 8'h01, {7'h18, i_fix_valid});
      put(8'h0f, 8'h05, l ? 40'h30302e3030 : i_dop_ascii);
      put(8'h10, 8'h09, i_alt_ascii);
      put(8'h11, 8'h01, 128'h0);
      run_msg(600 + 200 * l);
      chk(loc_seen, l + 1);
      run_msg(700 + 200 * l);
      chk(loc_seen, l + 1);
    end
    i_loc_en <= 1'b0;
    $display("path location test done");
    // two client frames, each with a refused start in mid-frame
    for (int f = 0; f < 2; f++)
    begin
      u_tlff_link_partner.bits.delete();
      {i_dev_type, i_status_flags, i_phase} <= $random(seed);
      i_version  <= $random(seed);
      i_cl_start <= 1'b1;
      @(posedge i_clk_sys);
      i_cl_start <= 1'b0;
      pay = {i_dev_type, i_status_flags, 22'h3fffff, 10'h3ff, i_phase, 8'h00, i_version, {68{1'b1}}};
      crc = 16'hffff;
      for (int i = 149; i >= 0; i--)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ pay[i]) ? 16'h1021 : 16'h0000);
      frame = {68'haaaaaaaaaaaaaaaa6, pay, crc};
      for (w = 0; w < 5000 && u_tlff_link_partner.bits.size() < 100; w++)
        @(posedge i_clk_sys);
      guard(w);
      i_dev_type <= ~i_dev_type;
      i_cl_start <= 1'b1;
      @(posedge i_clk_sys);
      i_cl_start <= 1'b0;
      for (w = 0; w < 5000 && o_cl_busy !== 1'b0; w++)
        @(posedge i_clk_sys);
      guard(w);
      repeat (2) @(posedge i_clk_sys);
      chk(u_tlff_link_partner.bits.size(), 234);
      for (int i = 0; i < 234; i++)
        chk(u_tlff_link_partner.bits[i], frame[233-i]);
    end
    $display("client frame test done");
    finish_test();
  end
endmodule : timing_link_frame_fields_tb_top
`default_nettype wire
